// [include/ivg_pkg.sv]
// ivg_pkg: register map, field layout and carriers of the vector generator
// assumes a 12-bit register offset and a 32-bit register data path
package ivg_pkg;
	localparam int unsigned ADDR_W = 12;
	localparam int unsigned NUM_SRC = 32;
	localparam logic [11:0] OFS_VECTOR_BASE = 12'h198;
	localparam logic [11:0] OFS_VECTOR_STEP = 12'h19c;
	localparam logic [11:0] OFS_VECTOR_RESULT = 12'h1a0;
	localparam logic [11:0] OFS_SOFTWARE_SET = 12'h1a4;
	localparam logic [11:0] DWORD_ALIGN_MASK = 12'hff8;
	localparam logic [11:0] DWORD_UPPER_OFS = 12'h004;
	// writable part of the base: top 19 bits, low 13 read as zero
	localparam logic [31:0] BASE_WRITE_MASK = 32'hffff_e000;
	localparam logic [31:0] BASE_RESET = 32'h0000_0000;
	localparam int unsigned PRI_BIT = 24;
	localparam int unsigned STEP_LSB = 0;
	localparam int unsigned STEP_W = 2;
	// the step bit that also steers eight-byte reads
	localparam int unsigned STEP_DWORD_BIT = 0;
	localparam logic [31:0] STEP_RESET = 32'h0000_0000;
	localparam logic [31:0] STEP_WRITE_MASK = 32'h0100_0003;
	localparam logic [31:0] SPACING_UNIT = 32'h0000_0100;
	localparam logic [31:0] RESULT_RESET = 32'h0000_0000;
	localparam logic [31:0] SOFT_RESET = 32'h0000_0000;
	localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

	typedef struct packed {
		logic valid;
		logic write;
		logic dword;
		logic [11:0] addr;
		logic [31:0] wdata;
	} ivg_req_t;

	typedef struct packed {
		logic ack;
		logic tea;
		logic [63:0] rdata;
	} ivg_resp_t;
endpackage

// [logic/ivg_vector_gen.sv]
// ivg_vector_gen: vector base, step, computed vector and software set registers
// assumes one processor register access per request pulse, answered one cycle later
//
// Behaviour
// - base resets to zero; top nineteen bits writable, rest read zero; all used.
// - priority bit 0 lets source 0 win, 1 lets source 31 win; resets 0.
// - two-bit step picks spacing 0x100, 0x200, 0x400 or 0x800; resets 00.
// - vector equals base plus spacing times the interrupt number.
// - vector register is read-only, resets zero, regenerated every cycle.
// - only 32-bit accesses; larger ones answer transfer error when enabled.
// - error off, step bit clear: eight-byte read returns aligned register twice.
// - error off, step bit set: eight-byte read returns aligned plus four twice.
// - writing ones to software set acts like those source lines toggling.
`timescale 1ns/1ps
module ivg_vector_gen (
	input wire logic clk, // 125 MHz register clock
	input wire logic rst_b, // power-on reset, synchronous
	input wire ivg_pkg::ivg_req_t regReq, // register access request
	input wire logic transferErrorEnable, // from the bus general control register
	input wire logic [31:0] pendingEnabled, // sources pending and enabled
	output ivg_pkg::ivg_resp_t regResp, // register access answer
	output logic [31:0] vectorOut, // current computed vector
	output logic [4:0] winningNumber, // number of the winning source
	output logic [31:0] softwareTriggerBits // one-cycle source toggles
);
	////////////////////////////////////////////////////////////////////////////
	// helpers

	function automatic logic [31:0] stepBytes(input logic [1:0] code);
		stepBytes = ivg_pkg::SPACING_UNIT << code;
	endfunction

	function automatic logic [4:0] pickSource(input logic [31:0] pend, input logic highFirst);
		logic [4:0] num;
		num = 5'h0;
		for (int i = 0; i < 32; i++)
		begin
			if (highFirst && pend[i])
				num = 5'(i); // last hit is highest
			if (!highFirst && pend[31 - i])
				num = 5'(31 - i); // last hit is lowest
		end
		pickSource = num;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// state

	logic [31:0] vectorBase;
	logic [31:0] vectorStep;
	logic [31:0] softSet;
	logic [31:0] next_vectorBase;
	logic [31:0] next_vectorStep;
	logic [31:0] next_softSet;
	logic [31:0] next_softwareTriggerBits;
	logic [31:0] next_vectorOut;
	logic [4:0] next_winningNumber;
	ivg_pkg::ivg_resp_t next_regResp;
	logic priorityOrderBit;
	logic [1:0] vectorStepField;

	assign priorityOrderBit = vectorStep[ivg_pkg::PRI_BIT];
	assign vectorStepField = vectorStep[ivg_pkg::STEP_LSB +: ivg_pkg::STEP_W];

	function automatic logic [31:0] readReg(input logic [11:0] addr);
		case (addr)
			ivg_pkg::OFS_VECTOR_BASE: readReg = vectorBase;
			ivg_pkg::OFS_VECTOR_STEP: readReg = vectorStep;
			ivg_pkg::OFS_VECTOR_RESULT: readReg = vectorOut;
			ivg_pkg::OFS_SOFTWARE_SET: readReg = softSet;
			default: readReg = ivg_pkg::UNMAPPED_DATA;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// vector generation

	always_comb
	begin
		next_winningNumber = pickSource(pendingEnabled, priorityOrderBit);
		// full base with its read-zero low bits takes part in the sum
		next_vectorOut = vectorBase + 32'(stepBytes(vectorStepField) * 32'(next_winningNumber));
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			vectorOut <= ivg_pkg::RESULT_RESET;
			winningNumber <= 5'h0;
		end
		else
		begin
			vectorOut <= next_vectorOut;
			winningNumber <= next_winningNumber;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// register access

	always_comb
	begin
		logic [11:0] dwAddr;
		logic [31:0] word;
		dwAddr = (regReq.addr & ivg_pkg::DWORD_ALIGN_MASK)
			+ (vectorStep[ivg_pkg::STEP_DWORD_BIT] ? ivg_pkg::DWORD_UPPER_OFS : 12'h0);
		word = ivg_pkg::UNMAPPED_DATA;
		next_vectorBase = vectorBase;
		next_vectorStep = vectorStep;
		next_softSet = softSet;
		next_softwareTriggerBits = 32'h0000_0000;
		next_regResp = '0;
		if (regReq.valid)
		begin
			next_regResp.ack = 1'b1;
			if (regReq.dword)
			begin
				// larger than a word: error, or duplicated word read, or write ignored
				if (transferErrorEnable)
					next_regResp.tea = 1'b1;
				else if (!regReq.write)
					word = readReg(dwAddr);
			end
			else if (regReq.write)
			begin
				case (regReq.addr)
					ivg_pkg::OFS_VECTOR_BASE:
						next_vectorBase = regReq.wdata & ivg_pkg::BASE_WRITE_MASK;
					ivg_pkg::OFS_VECTOR_STEP:
						next_vectorStep = regReq.wdata & ivg_pkg::STEP_WRITE_MASK;
					ivg_pkg::OFS_SOFTWARE_SET:
					begin
						next_softSet = regReq.wdata;
						next_softwareTriggerBits = regReq.wdata;
					end
					default:
						next_softSet = softSet;
				endcase
			end
			else
				word = readReg(regReq.addr);
			next_regResp.rdata = {word, word};
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			vectorBase <= ivg_pkg::BASE_RESET;
			vectorStep <= ivg_pkg::STEP_RESET;
			softSet <= ivg_pkg::SOFT_RESET;
			softwareTriggerBits <= 32'h0000_0000;
			regResp <= '0;
		end
		else
		begin
			vectorBase <= next_vectorBase;
			vectorStep <= next_vectorStep;
			softSet <= next_softSet;
			softwareTriggerBits <= next_softwareTriggerBits;
			regResp <= next_regResp;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks

	a_base_low_zero: assert property (@(posedge clk) disable iff (!rst_b)
		vectorBase[12:0] == 13'h0) else $error("base low bits not zero");

	a_pri_reset_low: assert property (@(posedge clk)
		$past(!rst_b) && !rst_b |=> vectorStep == 32'h0000_0000) else $error("step not reset");

	a_vector_formula: assert property (@(posedge clk) disable iff (!rst_b)
		$past(rst_b) |-> vectorOut == $past(vectorBase)
		+ 32'((ivg_pkg::SPACING_UNIT << $past(vectorStepField)) * 32'($past(next_winningNumber))))
		else $error("vector sum wrong");

	a_vector_read: assert property (@(posedge clk) disable iff (!rst_b)
		regReq.valid && !regReq.write && !regReq.dword && regReq.addr == 12'h1a0
		|=> regResp.rdata == {2{$past(vectorOut)}}) else $error("vector read stale");

	a_pick_order: assert property (@(posedge clk) disable iff (!rst_b)
		(pendingEnabled[0] && !priorityOrderBit) or (pendingEnabled[31] && priorityOrderBit)
		|=> winningNumber == ($past(priorityOrderBit) ? 5'h1f : 5'h00)) else $error("wrong winner");

	// a refused access may follow straight on, so tea may stay up for it
	a_tea_large: assert property (@(posedge clk) disable iff (!rst_b)
		regReq.valid && regReq.dword && transferErrorEnable
		|=> regResp.ack && regResp.tea
		##1 (!regResp.tea || $past(regReq.valid && regReq.dword && transferErrorEnable)))
		else $error("no transfer error");

	a_ack_next: assert property (@(posedge clk) disable iff (!rst_b)
		regReq.valid |=> regResp.ack) else $error("access not answered");

	a_dword_write_kept: assert property (@(posedge clk) disable iff (!rst_b)
		regReq.valid && regReq.dword && regReq.write
		|=> vectorBase == $past(vectorBase) && vectorStep == $past(vectorStep))
		else $error("eight-byte write landed");

	a_dword_low: assert property (@(posedge clk) disable iff (!rst_b)
		regReq.valid && regReq.dword && !regReq.write && !transferErrorEnable
		&& !vectorStep[0] && regReq.addr == 12'h19c
		|=> regResp.rdata == {2{$past(vectorBase)}}) else $error("low dword read wrong");

	a_dword_high: assert property (@(posedge clk) disable iff (!rst_b)
		regReq.valid && regReq.dword && !regReq.write && !transferErrorEnable
		&& vectorStep[0] && regReq.addr == 12'h198
		|=> regResp.rdata == {2{$past(vectorStep)}}) else $error("high dword read wrong");

	a_soft_pulse: assert property (@(posedge clk) disable iff (!rst_b)
		regReq.valid && regReq.write && !regReq.dword && regReq.addr == 12'h1a4
		|=> softwareTriggerBits == $past(regReq.wdata)) else $error("soft set lost");

	c_high_first: cover property (@(posedge clk) disable iff (!rst_b)
		priorityOrderBit && pendingEnabled[31] && pendingEnabled[0]);
	c_dword_dup: cover property (@(posedge clk) disable iff (!rst_b)
		regReq.valid && regReq.dword && !transferErrorEnable);
	c_dword_upper: cover property (@(posedge clk) disable iff (!rst_b)
		regReq.valid && regReq.dword && !transferErrorEnable && vectorStep[0]);
	c_tea: cover property (@(posedge clk) disable iff (!rst_b) regResp.tea);
endmodule

// [tb/ivg_bus_master.sv]
// ivg_bus_master: processor side model issuing single register accesses
// assumes the block answers one cycle after the request strobe
`timescale 1ns/1ps
module ivg_bus_master (
	input wire logic clk, // register clock
	output ivg_pkg::ivg_req_t regReq, // request to the block
	input wire ivg_pkg::ivg_resp_t regResp // answer from the block
);
	initial regReq = '0;

	////////////////////////////////////////////////////////////////
	// strobe for one edge, answer taken at the following edge
	task automatic access(input logic w, input logic dw, input logic [11:0] a, input logic [31:0] wd,
		output ivg_pkg::ivg_resp_t resp);
		@(negedge clk);
		regReq = {1'b1, w, dw, a, wd};
		@(negedge clk);
		regReq.valid = 1'b0;
		// answer taken at the edge that samples ack high, before that edge replaces it
		@(posedge clk);
		resp = regResp;
		@(negedge clk);
		// released address and data lines never keep the last value
		regReq.addr = ~regReq.addr;
		regReq.wdata = ~regReq.wdata;
	endtask
endmodule

// [tb/tb_top.sv]
// tb_top: register-level tests of the vector generator
// assumes ivg_pkg is compiled first
`timescale 1ns/1ps
module tb_top;
	logic clk;
	logic rst_b = 1'b0;
	logic transferErrorEnable = 1'b0;
	logic [31:0] pendingEnabled = '0;
	ivg_pkg::ivg_req_t regReq;
	ivg_pkg::ivg_resp_t regResp;
	logic [31:0] vectorOut;
	logic [4:0] winningNumber;
	logic [31:0] softwareTriggerBits;
	ivg_pkg::ivg_resp_t resp;
	logic [31:0] exp;
	int nMismatch = 0;
	int testsRun = 0;
	int n;

	ivg_vector_gen dut (.clk(clk), .rst_b(rst_b), .regReq(regReq), .transferErrorEnable(transferErrorEnable),
		.pendingEnabled(pendingEnabled), .regResp(regResp), .vectorOut(vectorOut),
		.winningNumber(winningNumber), .softwareTriggerBits(softwareTriggerBits));
	ivg_bus_master master (.clk(clk), .regReq(regReq), .regResp(regResp));

	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [65:0] e, input logic [65:0] g);
		testsRun++;
		if (g !== e)
		begin
			nMismatch++;
			$display("wrong value %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic acc(input int w, input int dw, input logic [11:0] a, input logic [31:0] wd,
		input logic [65:0] e, input string what);
		master.access(1'(w), 1'(dw), a, wd, resp);
		chk(what, e, resp);
	endtask

	task automatic stopTest();
		$display("comparisons %0d mismatches %0d", testsRun, nMismatch);
		if (nMismatch == 0 && testsRun > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (5) @(negedge clk);
		rst_b = 1'b1;
		for (int i = 0; i < 4; i++)
			acc(0, 0, ivg_pkg::OFS_VECTOR_BASE + 12'(4 * i), 0, 66'h2_0000_0000_0000_0000, "reset");
		acc(1, 0, ivg_pkg::OFS_VECTOR_BASE, 32'hffff_ffff, 66'h2_0000_0000_0000_0000, "base write");
		acc(0, 0, ivg_pkg::OFS_VECTOR_BASE, 0, {2'b10, {2{32'hffff_e000}}}, "base mask");
		acc(1, 0, ivg_pkg::OFS_VECTOR_STEP, 32'hffff_ffff, 66'h2_0000_0000_0000_0000, "step write");
		acc(0, 0, ivg_pkg::OFS_VECTOR_STEP, 0, {2'b10, {2{32'h0100_0003}}}, "step mask");
		acc(0, 0, 12'h1b0, 0, 66'h2_0000_0000_0000_0000, "unmapped");
		acc(1, 0, ivg_pkg::OFS_VECTOR_BASE, 32'h0001_0000, 66'h2_0000_0000_0000_0000, "base set");
		pendingEnabled = 32'h0000_0028;
		for (int p = 0; p < 2; p++)
			for (int c = 0; c < 4; c++)
			begin
				acc(1, 0, ivg_pkg::OFS_VECTOR_STEP, (32'(p) << 24) | 32'(c), 66'h2_0000_0000_0000_0000, "step");
				repeat (2) @(posedge clk);
				#1 n = p ? 5 : 3;
				exp = 32'h0001_0000 + (32'h0000_0100 << c) * 32'(n);
				chk("winner", 66'(n), 66'(winningNumber));
				chk("vector", 66'(exp), 66'(vectorOut));
				acc(0, 0, ivg_pkg::OFS_VECTOR_RESULT, 0, {2'b10, {2{exp}}}, "vector read");
			end
		acc(1, 0, ivg_pkg::OFS_VECTOR_RESULT, 32'h1234_5678, 66'h2_0000_0000_0000_0000, "ro write");
		acc(0, 1, ivg_pkg::OFS_VECTOR_BASE, 0, {2'b10, {2{32'h0100_0003}}}, "dword upper");
		acc(1, 0, ivg_pkg::OFS_VECTOR_STEP, 32'h0000_0002, 66'h2_0000_0000_0000_0000, "step low");
		acc(0, 1, ivg_pkg::OFS_VECTOR_STEP, 0, {2'b10, {2{32'h0001_0000}}}, "dword lower");
		fork
			acc(1, 0, ivg_pkg::OFS_SOFTWARE_SET, 32'h8000_0001, 66'h2_0000_0000_0000_0000, "soft write");
			begin
				// pulse stands from the taking edge up to the next one
				repeat (2) @(negedge clk);
				chk("trigger", 66'h0_0000_0000_8000_0001, 66'(softwareTriggerBits));
				@(negedge clk);
				chk("trigger end", 66'h0, 66'(softwareTriggerBits));
			end
		join
		acc(0, 0, ivg_pkg::OFS_SOFTWARE_SET, 0, {2'b10, {2{32'h8000_0001}}}, "soft read");
		@(negedge clk);
		pendingEnabled = '0;
		transferErrorEnable = 1'b1;
		repeat (2) @(posedge clk);
		#1 chk("idle vector", 66'h0_0000_0000_0001_0000, 66'(vectorOut));
		acc(0, 1, ivg_pkg::OFS_VECTOR_BASE, 0, 66'h3_0000_0000_0000_0000, "dword error");
		acc(1, 1, ivg_pkg::OFS_VECTOR_BASE, 32'hffff_ffff, 66'h3_0000_0000_0000_0000, "dword wr error");
		acc(0, 0, ivg_pkg::OFS_VECTOR_BASE, 0, {2'b10, {2{32'h0001_0000}}}, "base kept");
		stopTest();
	end

	initial
	begin
		#(20000 * 8);
		nMismatch++;
		stopTest();
	end
endmodule
